// >>> hdl/rtcev_pkg.sv
// Package of constants and types for the calendar clock event block
package rtcev_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STAT1 = 8'h00;
  localparam logic [7:0] OFF_STAT2 = 8'h04;
  localparam logic [7:0] OFF_ALM1  = 8'h08;
  localparam logic [7:0] OFF_ALM2  = 8'h0C;
  localparam logic [7:0] OFF_TIME0 = 8'h10;
  localparam logic [7:0] OFF_TIME1 = 8'h14;
  // Status 1 fields
  localparam int B_PWRUP = 0;   // Power-up flag (read), init command (write)
  localparam int B_SLOW  = 1;   // Supply-low flag
  localparam int B_H24   = 6;   // 24-hour mode
  // Status 2 fields
  localparam int B_A2E   = 1;   // Alarm two enable
  localparam int B_XTAL  = 4;   // Crystal output select
  localparam int B_A1E   = 5;   // Alarm one enable
  localparam int B_MIN   = 6;   // Minute output select
  localparam int B_FREQ  = 7;   // Frequency output select
  // Alarm byte valid bit
  localparam int B_VALID = 7;
  // Reset values
  localparam logic [7:0]  RST_STAT2 = 8'h80;
  localparam logic [23:0] RST_ALM1  = 24'h00_0080;
  localparam logic [23:0] RST_ALM2  = 24'h00_0000;
  // Oscillator timing
  localparam int XTAL_HZ   = 32768;
  localparam int SAMPLE_US = 15600;  // Supply sampling window
  localparam int EDGE_US   = 7810;   // Minute edge length
  localparam int SAMPLE_TK = (SAMPLE_US * XTAL_HZ + 999_999) / 1_000_000;
  localparam int EDGE_TK   = (EDGE_US * XTAL_HZ + 999_999) / 1_000_000;
  // Pin mode decode
  typedef enum logic [2:0] {
    PM_OFF  = 3'b000,
    PM_FREQ = 3'b001,
    PM_EDGE = 3'b010,
    PM_PER1 = 3'b011,
    PM_ALM1 = 3'b100,
    PM_PER2 = 3'b101,
    PM_XTAL = 3'b110
  } rtcev_mode_e;
  // Calendar time, BCD fields
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [2:0] week;
    logic       pm;
    logic [5:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcev_time_s;
endpackage

// >>> hdl/rtcev_core.sv
// Calendar clock with supply-low flag, write checks and event pin
`timescale 1ns/1ps
`default_nettype none
module rtcev_core
  import rtcev_pkg::*;
(
  input  wire logic        sys_clk,     // System clock
  input  wire logic        rst,         // Power-on reset
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output var  logic [31:0] prdata,      // APB read data
  output var  logic        pready,      // APB ready
  output var  logic        pslverr,     // APB error
  input  wire logic        xtalClk,     // 32.768 kHz oscillator
  input  wire logic        supplyLow,   // Supply at or below detect_level
  output var  logic        eventPinOut, // Event pin drive value
  output var  logic        eventPinOe   // Event pin pulls low
);
  import rtcev_pkg::*;

  logic [2:0]  xtalSync;     // Oscillator synchroniser and edge history
  logic [1:0]  lowSync;      // Supply comparator synchroniser
  logic        tick;         // Oscillator rising edge
  logic [14:0] pre;          // Divider to one second
  logic        secTick;      // One pulse per second
  logic        minCarry;     // Minute carry pulse
  logic [8:0]  edgeCnt;      // Ticks since last minute carry
  logic        edgeWin;      // Minute edge active
  logic        h24;          // 24-hour mode
  logic        powerUpFlag;  // power_up_flag
  logic        supplyLowFlag;// supply_low_flag
  logic        windowSeen;   // A sampling window ended since last read
  logic        lowSeen;      // Low level seen in this window
  logic [7:0]  stat2;        // Mode and alarm enables
  logic [23:0] alm [2];      // Alarm registers, first doubles as freq
  rtcev_time_s tm;           // Current calendar time
  rtcev_mode_e mode;         // Decoded pin mode
  logic        apbDo;        // Access completes this edge
  logic        wrEn;         // Write completes this edge
  logic        initCmd;      // Host initialisation
  logic        stat1Rd;      // Status 1 read completes
  logic [1:0]  almLatch;     // Alarm pin latches
  logic [1:0]  almMatch;     // Alarm compare results
  logic [1:0]  matchPrev;    // Previous compare results
  logic [1:0]  almOn;        // Alarm enabled in effect
  logic        edgeLatch;    // Minute edge latch
  logic        per1Run;      // Periodic one started
  logic [4:0]  fqOk;         // Per selected frequency level
  logic        fqLevel;      // AND of selected frequencies
  logic        pinLow;       // Combined pin assertion
  logic        pm24;         // Derived afternoon bit

  // BCD increment of one byte
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction

  // Low digit above nine
  function automatic logic badLo(input logic [7:0] v);
    return v[3:0] > 4'h9;
  endfunction

  // Days in a month, leap years counted
  function automatic logic [7:0] mDays(input logic [7:0] m,
                                       input logic [7:0] y);
    logic [7:0] yb;
    yb = {4'h0, y[7:4]} * 8'd10 + {4'h0, y[3:0]};
    unique case (m)
      8'h02: return (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Input synchronisers, two flops before any use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      xtalSync <= 3'b000;
      lowSync  <= 2'b00;
    end else begin
      xtalSync <= {xtalSync[1:0], xtalClk};
      lowSync  <= {lowSync[0], supplyLow};
    end
  end

  assign tick    = xtalSync[1] & ~xtalSync[2];
  assign secTick = tick & (pre == 15'h7FFF);

  // APB handshake, one wait state
  assign apbDo   = psel & penable & pready;
  assign wrEn    = apbDo & pwrite;
  assign initCmd = wrEn & (paddr == OFF_STAT1) & pwdata[B_PWRUP];
  assign stat1Rd = apbDo & ~pwrite & (paddr == OFF_STAT1);
  assign pm24    = (tm.hour >= 6'h12);

  // Divider, restarted by a write to OFF_TIME0 so the next carry is 1 s away
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre <= 15'h0000;
    end else if (wrEn && paddr == OFF_TIME0) begin
      pre <= 15'h0000;
    end else if (tick) begin
      pre <= pre + 15'h0001;
    end
  end

  // Minute edge window in oscillator ticks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edgeCnt <= 9'(EDGE_TK);
    end else if (minCarry) begin
      edgeCnt <= 9'h000;
    end else if (tick && edgeCnt < 9'(EDGE_TK)) begin
      edgeCnt <= edgeCnt + 9'h001;
    end
  end

  assign edgeWin = edgeCnt < 9'(EDGE_TK);

  // Supply sampling, only inside the window at each second start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      supplyLowFlag <= 1'b0;
      lowSeen       <= 1'b0;
      windowSeen    <= 1'b0;
    end else begin
      if (!supplyLowFlag && pre < 15'(SAMPLE_TK) && lowSync[1]) begin
        lowSeen <= 1'b1;
      end else if (tick && pre == 15'(SAMPLE_TK)) begin
        lowSeen <= 1'b0;
      end
      if (stat1Rd || initCmd) begin
        windowSeen <= 1'b0;
      end
      if (tick && pre == 15'(SAMPLE_TK)) begin
        windowSeen <= 1'b1;
      end
      if (tick && pre == 15'(SAMPLE_TK) && lowSeen) begin
        supplyLowFlag <= 1'b1;
      end else if (initCmd || (stat1Rd && windowSeen)) begin
        supplyLowFlag <= 1'b0;
      end
    end
  end

  // Status and alarm registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powerUpFlag <= 1'b1;
      h24         <= 1'b0;
      stat2       <= RST_STAT2;
      alm[0]      <= RST_ALM1;
      alm[1]      <= RST_ALM2;
    end else if (initCmd) begin
      powerUpFlag <= 1'b0;
      h24         <= pwdata[B_H24];
      stat2       <= 8'h00;
      alm[0]      <= 24'h00_0000;
      alm[1]      <= 24'h00_0000;
    end else if (wrEn) begin
      unique case (paddr)
        OFF_STAT1: h24    <= pwdata[B_H24];
        OFF_STAT2: stat2  <= pwdata[7:0];
        OFF_ALM1:  alm[0] <= pwdata[23:0];
        OFF_ALM2:  alm[1] <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // Calendar counting and checked host writes
  always_ff @(posedge sys_clk or posedge rst) begin
    logic [7:0] m;
    logic [7:0] d;
    logic [7:0] y;
    logic [7:0] h;
    if (rst) begin
      tm       <= '{year: 8'h00, month: 8'h01, day: 8'h01,
                    default: '0};
      minCarry <= 1'b0;
    end else begin
      m = 8'h01;
      d = 8'h01;
      y = 8'h00;
      h = 8'h00;
      minCarry <= 1'b0;
      if (initCmd) begin
        tm <= '{year: 8'h00, month: 8'h01, day: 8'h01, default: '0};
      end else if (wrEn && paddr == OFF_TIME0) begin
        tm.sec <= pwdata[7:0];
        tm.min <= (pwdata[15:8] > 8'h59 || badLo(pwdata[15:8]))
                  ? 8'h00 : pwdata[15:8];
        h = {2'b00, pwdata[21:16]};
        if (badLo(h) || (h24 ? h > 8'h23 : h > 8'h11)) begin
          h = 8'h00;
        end
        tm.hour <= h[5:0];
        tm.pm   <= h24 ? 1'b0 : pwdata[22];
        tm.week <= (pwdata[26:24] == 3'd7) ? 3'd0 : pwdata[26:24];
      end else if (wrEn && paddr == OFF_TIME1) begin
        d = pwdata[7:0];
        m = pwdata[15:8];
        y = pwdata[23:16];
        if (m == 8'h00 || m > 8'h12 || badLo(m)) begin
          m = 8'h01;
        end
        if (d == 8'h00 || d > 8'h31 || badLo(d)) begin
          d = 8'h01;
        end
        if (badLo(y) || y[7:4] > 4'h9) begin
          y = 8'h00;
        end
        if (d > mDays(m, y)) begin
          d = 8'h01;
          if (m == 8'h12) begin
            m = 8'h01;
            y = (y == 8'h99) ? 8'h00 : bcdInc(y);
          end else begin
            m = bcdInc(m);
          end
        end
        tm.day   <= d;
        tm.month <= m;
        tm.year  <= y;
      end else if (secTick) begin
        if (tm.sec >= 8'h59 || badLo(tm.sec)) begin
          tm.sec   <= 8'h00;
          minCarry <= 1'b1;
          if (tm.min == 8'h59) begin
            tm.min <= 8'h00;
            if (h24 ? tm.hour == 6'h23 : tm.hour == 6'h11) begin
              tm.hour <= 6'h00;
              if (!h24) begin
                tm.pm <= ~tm.pm;
              end
              if (h24 || tm.pm) begin
                tm.week <= (tm.week == 3'd6) ? 3'd0 : tm.week + 3'd1;
                if (tm.day >= mDays(tm.month, tm.year)) begin
                  tm.day <= 8'h01;
                  if (tm.month == 8'h12) begin
                    tm.month <= 8'h01;
                    tm.year  <= (tm.year == 8'h99) ? 8'h00
                                                   : bcdInc(tm.year);
                  end else begin
                    tm.month <= bcdInc(tm.month);
                  end
                end else begin
                  tm.day <= bcdInc(tm.day);
                end
              end
            end else begin
              tm.hour <= 6'(bcdInc({2'b00, tm.hour}));
            end
          end else begin
            tm.min <= bcdInc(tm.min);
          end
        end else begin
          tm.sec <= bcdInc(tm.sec);
        end
      end
    end
  end

  // Pin mode from the four select bits, crystal wins
  always_comb begin
    if (stat2[B_XTAL]) begin
      mode = PM_XTAL;
    end else begin
      unique case ({stat2[B_A1E], stat2[B_MIN], stat2[B_FREQ]})
        3'b001, 3'b101: mode = PM_FREQ;
        3'b010, 3'b110: mode = PM_EDGE;
        3'b011:         mode = PM_PER1;
        3'b100:         mode = PM_ALM1;
        3'b111:         mode = PM_PER2;
        default:        mode = PM_OFF;
      endcase
    end
  end

  assign almOn = {stat2[B_A2E], mode == PM_ALM1};

  // Alarm compare and latch, one per alarm
  for (genvar i = 0; i < 2; i++) begin : g_alm
    // A byte takes part only when its valid bit is set
    assign almMatch[i] =
      (~alm[i][B_VALID] | alm[i][2:0] == tm.week) &
      (~alm[i][8+B_VALID] |
       alm[i][14:8] == {(h24 ? pm24 : tm.pm), tm.hour}) &
      (~alm[i][16+B_VALID] | alm[i][22:16] == tm.min[6:0]) &
      (alm[i][B_VALID] | alm[i][8+B_VALID] | alm[i][16+B_VALID]);
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        matchPrev[i] <= 1'b0;
        almLatch[i]  <= 1'b0;
      end else begin
        matchPrev[i] <= almMatch[i];
        if (!almOn[i]) begin
          almLatch[i] <= 1'b0;
        end else if (almMatch[i] && (!matchPrev[i] || minCarry)) begin
          almLatch[i] <= 1'b1;
        end
      end
    end
  end

  // Selected frequencies, high when each clock is high
  for (genvar k = 0; k < 5; k++) begin : g_fq
    assign fqOk[k] = ~alm[0][7-k] | pre[14-k];
  end
  assign fqLevel = &fqOk;

  // Minute edge latch and periodic one start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edgeLatch <= 1'b0;
      per1Run   <= 1'b0;
    end else begin
      if (mode != PM_EDGE) begin
        edgeLatch <= 1'b0;
      end else if (edgeWin) begin
        edgeLatch <= 1'b1;
      end
      if (mode != PM_PER1) begin
        per1Run <= 1'b0;
      end else if (minCarry) begin
        per1Run <= 1'b1;
      end
    end
  end

  // Pin assertion per mode, alarm two in any mode
  always_comb begin
    unique case (mode)
      PM_XTAL: pinLow = ~xtalSync[2];
      PM_FREQ: pinLow = ~fqLevel;
      PM_EDGE: pinLow = edgeLatch;
      PM_PER1: pinLow = per1Run & (tm.sec < 8'h30);
      PM_ALM1: pinLow = almLatch[0];
      PM_PER2: pinLow = edgeWin;
      default: pinLow = 1'b0;
    endcase
    pinLow = pinLow | almLatch[1];
  end

  // Open-drain pin registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eventPinOut <= 1'b0;
      eventPinOe  <= 1'b0;
    end else begin
      eventPinOut <= 1'b0;
      eventPinOe  <= pinLow;
    end
  end

  // APB answer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        unique case (paddr)
          OFF_STAT1: prdata <= {25'h0, h24, 4'h0,
                                supplyLowFlag, powerUpFlag};
          OFF_STAT2: prdata <= {24'h0, stat2};
          OFF_ALM1:  prdata <= {8'h0, alm[0]};
          OFF_ALM2:  prdata <= {8'h0, alm[1]};
          OFF_TIME0: prdata <= {5'h0, tm.week, 1'b0,
                                (h24 ? pm24 : tm.pm), tm.hour,
                                tm.min, tm.sec};
          OFF_TIME1: prdata <= {8'h0, tm.year, tm.month, tm.day};
          default:   pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/rtcev_osc_model.sv
// Oscillator and supply comparator that stand outside the block
`timescale 1ns/1ps
`default_nettype none
module rtcev_osc_model #(
  parameter int HALF_NS = 40  // Half period of the oscillator
) (
  input  wire logic lowReq,    // Bench asks for a sagging supply
  output var  logic xtalClk,   // Free-running oscillator
  output var  logic supplyLow  // Comparator verdict, high when low
);
  // The crystal runs freely from time zero, so it never stands still
  initial xtalClk = 1'b0;
  always #(HALF_NS) xtalClk = ~xtalClk;
  // Comparator follows the supply level directly
  assign supplyLow = lowReq;
endmodule
`default_nettype wire

// >>> bench/rtcev_core_assertions.sv
// Port timing checks for the calendar clock event block
`timescale 1ns/1ps
`default_nettype none
module rtcev_core_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        xtalClk,
  input wire logic        supplyLow,
  input wire logic        eventPinOut,
  input wire logic        eventPinOe
);
  import rtcev_pkg::*;
  // One clock domain, idle while reset is held
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Answer comes one cycle after the first access cycle
  access_ready_a: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready after first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  bad_addr_a: assert property (pready && (paddr > OFF_TIME1 ||
    paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped offset answered without error");
  good_addr_a: assert property (pready && paddr <= OFF_TIME1 &&
    paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped offset answered with error");
  pin_drain_a: assert property (eventPinOut == 1'b0)
    else $error("event pin driven high");
  mode_off_a: assert property (psel && penable && pready && pwrite &&
    paddr == OFF_STAT2 && pwdata[7:0] == 8'h00 |-> ##[1:4] !eventPinOe)
    else $error("pin still low with every mode off");
  powerup_pin_a: assert property ($fell(rst) |-> ##[1:20] eventPinOe)
    else $error("no low half second after power-up");
endmodule
`default_nettype wire

// >>> bench/rtcev_core_tb_top.sv
// Self-checking bench for the calendar clock event block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); \
  end \
end
module rtcev_core_tb_top;
  import rtcev_pkg::*;
  // One write followed by a read-back of the same register
  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } rtcev_row_s;
  logic        sys_clk = 1'b0;  // 100 MHz system clock
  logic        rst     = 1'b1;  // Power-on reset
  logic        psel    = 1'b0;  // Bus request lines
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtalClk;         // Oscillator from the model
  logic        supplyLow;       // Comparator from the model
  logic        lowReq  = 1'b0;  // Bench control of the supply
  logic        eventPinOut;
  logic        eventPinOe;
  logic [31:0] rd;
  logic        err;
  logic        hi;
  logic        lo;
  int          n_errors    = 0;
  int          check_count = 0;
  // Checked write data and expected read-back, 24-hour mode first
  rtcev_row_s rows [0:22] = '{
    '{OFF_TIME1, 32'h0024_0015, 32'h0024_0115},
    '{OFF_TIME1, 32'h0024_1315, 32'h0024_0115},
    '{OFF_TIME1, 32'h0024_0A15, 32'h0024_0115},
    '{OFF_TIME1, 32'h0024_0300, 32'h0024_0301},
    '{OFF_TIME1, 32'h0024_0332, 32'h0024_0301},
    '{OFF_TIME1, 32'h0024_031B, 32'h0024_0301},
    '{OFF_TIME1, 32'h0024_0230, 32'h0024_0301},
    '{OFF_TIME1, 32'h0024_0431, 32'h0024_0501},
    '{OFF_TIME1, 32'h0024_0229, 32'h0024_0229},
    '{OFF_TIME0, 32'h0024_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0030_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h001A_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0313_5910, 32'h0353_5910},
    '{OFF_TIME0, 32'h0051_0000, 32'h0011_0000},
    '{OFF_TIME0, 32'h0623_5959, 32'h0663_5959},
    '{OFF_TIME0, 32'h0000_6000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0000_4B00, 32'h0000_0000},
    '{OFF_TIME0, 32'h0700_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0000_0075, 32'h0000_0075},
    '{OFF_STAT1, 32'h0000_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0012_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0020_0000, 32'h0000_0000},
    '{OFF_TIME0, 32'h0051_2000, 32'h0051_2000}
  };
  // Clock of 10 ns period
  always #5 sys_clk = ~sys_clk;
  rtcev_osc_model osc_u (
    .lowReq    (lowReq),
    .xtalClk   (xtalClk),
    .supplyLow (supplyLow)
  );
  rtcev_core dut_u (
    .sys_clk (sys_clk), .rst (rst), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
    .pready (pready), .pslverr (pslverr), .xtalClk (xtalClk),
    .supplyLow (supplyLow), .eventPinOut (eventPinOut),
    .eventPinOe (eventPinOe)
  );
  // One bus transfer: setup, access until ready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error %0t: no ready from the bus", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // Pin level a few cycles after its cause
  task automatic pinchk(input logic e);
    repeat (6) @(posedge sys_clk);
    `CHK(eventPinOe, e)
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge xtalClk);
    @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 22400 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    test_done();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK(eventPinOe, 1'b1)
    rchk(OFF_STAT1, 32'h0000_0001);
    rchk(OFF_STAT2, 32'h0000_0080);
    rchk(OFF_ALM1, 32'h0000_0080);
    rchk(OFF_ALM2, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, OFF_STAT1, 32'h0000_0041);
    pinchk(1'b0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].e);
    end
    // Supply sag after the window has closed is ignored, one across the next window sets the flag
    apb(1'b1, OFF_TIME0, 32'h0051_2000);
    ticks(700);
    lowReq <= 1'b1;
    ticks(300);
    rchk(OFF_STAT1, 32'h0000_0000);
    apb(1'b1, OFF_TIME0, 32'h0051_2000);
    ticks(600);
    lowReq <= 1'b0;
    ticks(50);
    rchk(OFF_STAT1, 32'h0000_0002);
    rchk(OFF_STAT1, 32'h0000_0000);
    rchk(OFF_TIME0, 32'h0051_2000);
    // Alarm two at minute 20, then clear and re-arm while matching
    // Enable first, then arm, so the match rises while enabled
    apb(1'b1, OFF_STAT2, 32'h0000_0002);
    apb(1'b1, OFF_ALM2, 32'h00A0_0000);
    pinchk(1'b1);
    apb(1'b1, OFF_STAT2, 32'h0000_0000);
    pinchk(1'b0);
    apb(1'b1, OFF_STAT2, 32'h0000_0002);
    pinchk(1'b0);
    // Alarm one holds the pin until its mode is left
    apb(1'b1, OFF_STAT2, 32'h0000_0020);
    apb(1'b1, OFF_ALM1, 32'h00A0_0000);
    pinchk(1'b1);
    apb(1'b1, OFF_ALM1, 32'h0000_0000);
    pinchk(1'b1);
    apb(1'b1, OFF_STAT2, 32'h0000_0000);
    pinchk(1'b0);
    // Sixteen hertz alone: low for the first 1024 ticks, then high
    apb(1'b1, OFF_ALM1, 32'h0000_0008);
    apb(1'b1, OFF_TIME0, 32'h0051_2000);
    apb(1'b1, OFF_STAT2, 32'h0000_0080);
    pinchk(1'b1);
    ticks(1100);
    `CHK(eventPinOe, 1'b0)
    apb(1'b1, OFF_ALM1, 32'h0000_0000);
    pinchk(1'b0);
    // Crystal output makes the pin toggle
    apb(1'b1, OFF_STAT2, 32'h0000_0010);
    hi = 1'b0;
    lo = 1'b0;
    repeat (24) begin
      @(posedge sys_clk);
      if (eventPinOe === 1'b1) hi = 1'b1;
      else if (eventPinOe === 1'b0) lo = 1'b1;
    end
    `CHK({hi, lo}, 2'b11)
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(eventPinOe, 1'b0)
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK(eventPinOe, 1'b1)
    rchk(OFF_STAT1, 32'h0000_0001);
    test_done();
  end
endmodule
bind rtcev_core rtcev_core_checker chk_u (
  .sys_clk (sys_clk), .rst (rst), .psel (psel), .penable (penable),
  .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
  .pready (pready), .pslverr (pslverr), .xtalClk (xtalClk),
  .supplyLow (supplyLow), .eventPinOut (eventPinOut),
  .eventPinOe (eventPinOe)
);
`default_nettype wire
